// >>> logic/cfi_consts.vh
/*
  Constants for the configuration-memory fault injection port.
  Assumes inclusion by bare name from the design files under logic/.
*/
`ifndef CFI_CONSTS_VH
`define CFI_CONSTS_VH

// Host command word, shifted in LSB first
`define CFI_CMD_W 8
`define CFI_ADDR_W 6
`define CFI_OP_LSB 6
`define CFI_OP_W 2
`define CFI_OP_STATUS 2'h0
`define CFI_OP_INJECT 2'h1
`define CFI_OP_SCRUB 2'h2
`define CFI_OP_RESET 2'h3

// Modelled configuration memory
`define CFI_MEM_BITS 64
`define CFI_MEM_INIT 64'hA5A5_5A5A_C3C3_3C3C

// Error message stream
`define CFI_EMR_W 32
`define CFI_CNT_W 8

// Status word shifted out: {message, count, flags}
`define CFI_FLAG_W 8
`define CFI_STAT_W 48

// Done pulse length in test-clock rising edges
`define CFI_DONE_TCK 5'h14
`define CFI_DONE_W 5

// Exported oscillator: half period in sys_clk cycles
`define CFI_OSC_HALF 3'h4
`define CFI_OSC_W 3

`endif

// >>> logic/cfi_msg_buf.v
/*
  Two-entry buffer for error message words, valid/ready on both sides.
  Assumes both sides run on sys_clk; reset_n is asynchronous, active low.
*/
`timescale 1ns/100ps
`include "cfi_consts.vh"

module cfi_msg_buf (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Filling side
  input wire in_valid,
  output wire in_ready,
  input wire [`CFI_EMR_W-1:0] in_data,
  // Draining side
  output wire out_valid,
  input wire out_ready,
  output wire [`CFI_EMR_W-1:0] out_data
);

  reg [`CFI_EMR_W-1:0] slot0;
  reg [`CFI_EMR_W-1:0] slot1;
  reg [1:0] fill;
  wire push;
  wire pop;

  // Full only at two words, so the source really stalls
  assign in_ready = (fill != 2'h2);
  assign out_valid = (fill != 2'h0);
  assign out_data = slot0;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Slot0 is always the head word
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      slot0 <= {`CFI_EMR_W{1'b0}};
      slot1 <= {`CFI_EMR_W{1'b0}};
      fill <= 2'h0;
    end else begin
      if (pop) begin
        slot0 <= (fill == 2'h2) ? slot1 : in_data;
        if (push && fill == 2'h2) begin
          slot1 <= in_data;
        end
      end else if (push) begin
        if (fill == 2'h0) begin
          slot0 <= in_data;
        end else begin
          slot1 <= in_data;
        end
      end
      if (push && !pop) begin
        fill <= fill + 2'h1;
      end else if (pop && !push) begin
        fill <= fill - 2'h1;
      end
    end
  end

endmodule

// >>> logic/cfi_port.v
/*
  Fault injection port: serial host command link, modelled configuration
  memory with checker, scrub and bit-flip injection, done pulses, and the
  error message stream sink.
  Assumes the host drives tck/tms/tdi asynchronously to sys_clk and the
  message unloader runs on sys_clk, like both sides of the message buffer.
*/
// What this block does
// [R1] The unloader drives crc_error_in high while the memory checker reports an error.
// [R2] The unloader presents the error message word on emr_data with streaming data rules.
// [R3] The unloader asserts emr_valid only while emr_data holds a valid word.
// [R4] Module reset comes from the host, by reset_n or by a reset command over the link.
// [R5] A completed injection raises error_injected for 20 test-clock cycles.
// [R6] A completed scrub raises error_scrubbed for 20 test-clock cycles.
// [R7] The block exports a clock from its internal oscillator on osc_clk_out.
// [R8] The memory has error detection, scrub correction and forced upset by injection.
// [R9] Commands arrive over the serial test link and status returns over the same link.
// [R10] Injection inverts the addressed memory bit rather than forcing a value.
// [R11] During reset both done outputs are low and any partial command is dropped.
`timescale 1ns/100ps
`include "cfi_consts.vh"

module cfi_port (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Serial test link from host
  input wire tck,
  input wire tms,
  input wire tdi,
  output reg tdo_out,
  output reg tdo_oe_n,
  // Error message stream from unloader
  input wire crc_error_in,
  input wire [`CFI_EMR_W-1:0] emr_data,
  input wire emr_valid,
  output wire emr_ready,
  // Completion pulses and exported clock
  output reg error_injected,
  output reg error_scrubbed,
  output reg osc_clk_out
);

  localparam ST_IDLE = 2'b01;
  localparam ST_SHIFT = 2'b10;

  reg tck_s1, tck_s2, tck_s3;
  reg tms_s1, tms_s2;
  reg tdi_s1, tdi_s2;
  reg [1:0] state;
  reg [`CFI_CMD_W-1:0] cmd;
  reg [`CFI_STAT_W-1:0] status_sh;
  reg [`CFI_MEM_BITS-1:0] config_mem;
  reg crc_seen;
  reg [`CFI_EMR_W-1:0] last_msg;
  reg [`CFI_CNT_W-1:0] msg_count;
  reg [`CFI_OSC_W-1:0] osc_cnt;
  reg [`CFI_DONE_W-1:0] done_cnt [0:1];
  wire tck_rise;
  wire tck_fall;
  wire frame_end;
  wire [1:0] done_start;
  wire [1:0] done_level;
  wire mem_mismatch;
  wire soft_reset;
  wire buf_valid;
  wire buf_ready;
  wire [`CFI_EMR_W-1:0] buf_data;
  wire [`CFI_FLAG_W-1:0] flags;

  // Opcode decode, shared by all command consumers
  function cmd_is;
    input [`CFI_CMD_W-1:0] c;
    input [`CFI_OP_W-1:0] op;
    begin
      cmd_is = (c[`CFI_OP_LSB +: `CFI_OP_W] == op);
    end
  endfunction

  // Link pins cross into sys_clk; tck gets a third stage for edges
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tck_s1 <= 1'b0;
      tck_s2 <= 1'b0;
      tck_s3 <= 1'b0;
      tms_s1 <= 1'b1;
      tms_s2 <= 1'b1;
      tdi_s1 <= 1'b0;
      tdi_s2 <= 1'b0;
    end else begin
      tck_s1 <= tck;
      tck_s2 <= tck_s1;
      tck_s3 <= tck_s2;
      tms_s1 <= tms;
      tms_s2 <= tms_s1;
      tdi_s1 <= tdi;
      tdi_s2 <= tdi_s1;
    end
  end

  assign tck_rise = tck_s2 & ~tck_s3;
  assign tck_fall = ~tck_s2 & tck_s3;
  assign frame_end = tck_rise & tms_s2 & (state == ST_SHIFT);
  // [R4] Host reset command
  assign soft_reset = frame_end & cmd_is(cmd, `CFI_OP_RESET);
  // [R10] Injection flips one bit
  assign done_start[0] = frame_end & cmd_is(cmd, `CFI_OP_INJECT);
  // [R8] Scrub restores golden image
  assign done_start[1] = frame_end & cmd_is(cmd, `CFI_OP_SCRUB);

  // [R8] Checker compares memory with golden image
  assign mem_mismatch = (config_mem != `CFI_MEM_INIT);
  assign flags = {4'h0, state == ST_SHIFT, crc_seen, mem_mismatch,
                  error_injected | error_scrubbed};

  // [R9] Serial command shift and frame decode
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      // [R11] Partial command dropped
      state <= ST_IDLE;
      cmd <= {`CFI_CMD_W{1'b0}};
      status_sh <= {`CFI_STAT_W{1'b0}};
    end else begin
      case (state)
        ST_IDLE: begin
          // Reload so the first bit is ready before the first rise
          status_sh <= {last_msg, msg_count, flags};
          if (tck_rise && !tms_s2) begin
            state <= ST_SHIFT;
            cmd <= {tdi_s2, cmd[`CFI_CMD_W-1:1]};
            status_sh <= {1'b0, last_msg, msg_count, flags[`CFI_FLAG_W-1:1]};
          end
        end
        ST_SHIFT: begin
          if (tck_rise && tms_s2) begin
            state <= ST_IDLE;
          end else if (tck_rise) begin
            cmd <= {tdi_s2, cmd[`CFI_CMD_W-1:1]};
            status_sh <= {1'b0, status_sh[`CFI_STAT_W-1:1]};
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // [R9] Status returns on tdo, updated on falling tck
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tdo_out <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else begin
      tdo_oe_n <= (state != ST_SHIFT);
      if (tck_fall || state == ST_IDLE) begin
        tdo_out <= status_sh[0];
      end
    end
  end

  // Memory model: inject and scrub act at frame end
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      config_mem <= `CFI_MEM_INIT;
    end else if (done_start[1]) begin
      config_mem <= `CFI_MEM_INIT;
    end else if (done_start[0]) begin
      // [R10] Invert addressed bit
      config_mem[cmd[`CFI_ADDR_W-1:0]] <= ~config_mem[cmd[`CFI_ADDR_W-1:0]];
    end
  end

  // [R1] Sticky checker flag; a new error wins over the clearing scrub
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      crc_seen <= 1'b0;
    end else if (crc_error_in) begin
      crc_seen <= 1'b1;
    end else if (done_start[1] || soft_reset) begin
      crc_seen <= 1'b0;
    end
  end

  // [R5] [R6] Done pulse counters in tck edges
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_done
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          done_cnt[gi] <= {`CFI_DONE_W{1'b0}};
        end else if (soft_reset) begin
          done_cnt[gi] <= {`CFI_DONE_W{1'b0}};
        end else if (done_start[gi]) begin
          done_cnt[gi] <= `CFI_DONE_TCK;
        end else if (tck_rise && done_cnt[gi] != {`CFI_DONE_W{1'b0}}) begin
          done_cnt[gi] <= done_cnt[gi] - 5'h01;
        end
      end
      assign done_level[gi] = (done_cnt[gi] != {`CFI_DONE_W{1'b0}});
    end
  endgenerate

  // [R11] Done outputs low in reset
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      error_injected <= 1'b0;
      error_scrubbed <= 1'b0;
    end else begin
      // [R5] Injection done pulse
      error_injected <= done_level[0];
      // [R6] Scrub done pulse
      error_scrubbed <= done_level[1];
    end
  end

  // [R3] Words enter the buffer only with emr_valid
  cfi_msg_buf u_buf (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .in_valid(emr_valid),
    .in_ready(emr_ready),
    .in_data(emr_data),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );

  // Drain stalls while a status word is shifting, so it stays coherent
  assign buf_ready = (state == ST_IDLE);

  // [R2] Latest message word kept for status
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      last_msg <= {`CFI_EMR_W{1'b0}};
      msg_count <= {`CFI_CNT_W{1'b0}};
    end else if (buf_valid && buf_ready) begin
      last_msg <= buf_data;
      msg_count <= msg_count + 8'h01;
    end else if (soft_reset) begin
      last_msg <= {`CFI_EMR_W{1'b0}};
      msg_count <= {`CFI_CNT_W{1'b0}};
    end
  end

  // [R7] Exported oscillator clock from divider
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_cnt <= {`CFI_OSC_W{1'b0}};
      osc_clk_out <= 1'b0;
    end else if (osc_cnt == `CFI_OSC_HALF - 3'h1) begin
      osc_cnt <= {`CFI_OSC_W{1'b0}};
      osc_clk_out <= ~osc_clk_out;
    end else begin
      osc_cnt <= osc_cnt + 3'h1;
    end
  end

endmodule

// >>> test/cfi_port_asserts.sv
/* Port checker for cfi_port.
   Assumes a bind into cfi_port from the bench top. */
`timescale 1ns/100ps
module cfi_port_asserts (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Watched ports
  input wire tck,
  input wire tms,
  input wire tdo_oe_n,
  input wire error_injected,
  input wire error_scrubbed,
  input wire osc_clk_out
);
  reg [2:0] ts;
  reg [4:0] n_inj;
  reg [4:0] n_scr;
  wire t_up = ts[1] & ~ts[2];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Tck rises counted while a pulse stands, same sync depth as the port
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ts <= 3'h0;
      n_inj <= 5'h00;
      n_scr <= 5'h00;
    end else begin
      ts <= {ts[1:0], tck};
      n_inj <= error_injected ? n_inj + t_up : 5'h00;
      n_scr <= error_scrubbed ? n_scr + t_up : 5'h00;
    end
  end
  // Reset, pulse length, cause, link enable timing and oscillator period
  property p_rst; disable iff (1'b0) !reset_n |-> !error_injected && !error_scrubbed && tdo_oe_n;
  endproperty
  a_rst: assert property (p_rst) else $error("output active in reset");
  property p_inj_len; $fell(error_injected) |-> n_inj == 5'h14; endproperty
  a_inj_len: assert property (p_inj_len) else $error("inject pulse length");
  property p_scr_len; $fell(error_scrubbed) |-> n_scr == 5'h14; endproperty
  a_scr_len: assert property (p_scr_len) else $error("scrub pulse length");
  property p_inj_src; $rose(error_injected) |-> $past(tms, 4) && !error_scrubbed; endproperty
  a_inj_src: assert property (p_inj_src) else $error("inject pulse without frame end");
  property p_scr_src; $rose(error_scrubbed) |-> $past(tms, 4) && !error_injected; endproperty
  a_scr_src: assert property (p_scr_src) else $error("scrub pulse without frame end");
  property p_oe_on; $fell(tdo_oe_n) |-> !$past(tms, 4); endproperty
  a_oe_on: assert property (p_oe_on) else $error("tdo enabled outside shift");
  property p_oe_off; $rose(tdo_oe_n) |-> $past(tms, 4); endproperty
  a_oe_off: assert property (p_oe_off) else $error("tdo released without frame end");
  property p_osc; $changed(osc_clk_out) |=> $stable(osc_clk_out) [*3] ##1 $changed(osc_clk_out);
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator period");
endmodule

// >>> test/cfi_unloader_model.sv
/* Unloader model: checker flag and message words toward the port.
   Assumes the sys_clk domain; the bench drives send and crc_req. */
`timescale 1ns/100ps
module cfi_unloader_model (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Bench control
  input wire send,
  input wire crc_req,
  // Stream toward the port
  output reg crc_error_in,
  output reg [31:0] emr_data,
  output reg emr_valid,
  input wire emr_ready,
  // Tally of words taken
  output reg [7:0] n_sent,
  output reg [31:0] last_sent
);
  integer seed = 93439;
  // flag follows request, word held until taken
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      crc_error_in <= 1'b0;
      emr_data <= 32'h0;
      emr_valid <= 1'b0;
      n_sent <= 8'h00;
      last_sent <= 32'h0;
    end else begin
      crc_error_in <= crc_req;
      if (emr_valid && emr_ready) begin
        n_sent <= n_sent + 8'h01;
        last_sent <= emr_data;
      end
      // Random gaps; idle data toggles so a stale word never looks held
      if (!emr_valid || emr_ready) begin
        emr_valid <= send && ($random(seed) & 3) != 0;
        emr_data <= send ? $random(seed) : ~emr_data;
      end
    end
  end
endmodule

// >>> test/cfi_port_bench.sv
/* Bench for cfi_port: link driver, unloader model, queued checks.
   Assumes the logic/ files and the test/ model and checker. */
`timescale 1ns/100ps
module cfi_port_bench;
  reg sys_clk = 1'b0;
  reg reset_n = 1'b1;
  reg tck = 1'b0;
  reg tms = 1'b1;
  reg tdi = 1'b0;
  reg send = 1'b0;
  reg crc_req = 1'b0;
  reg crc_exp = 1'b0;
  reg full = 1'b0;
  reg [5:0] a = 6'h00;
  reg [7:0] base = 8'h00;
  reg [63:0] flips = 64'h0;
  reg [47:0] got, eq[$], mq[$];
  reg [1:0] dp = 2'h0;
  reg [1:0] pq[$];
  integer n_fail = 0, compares = 0, seed = 93439, nb = 0, k;
  wire tdo_out, tdo_oe_n, crc_error_in, emr_valid, emr_ready, error_injected, error_scrubbed;
  wire [31:0] emr_data, last_sent;
  wire [7:0] n_sent;
  localparam [21:0] ops_seq = {2'h0, 2'h2, 2'h0, 2'h3, 2'h1, 2'h2, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0};
  always #5 sys_clk = ~sys_clk;
  // Host test clock runs free, unrelated in phase
  always #62.5 tck = ~tck;
  cfi_port i_cfi_port (.sys_clk(sys_clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n), .crc_error_in(crc_error_in), .emr_data(emr_data),
    .emr_valid(emr_valid), .emr_ready(emr_ready), .error_injected(error_injected),
    .error_scrubbed(error_scrubbed), .osc_clk_out());
  cfi_unloader_model i_cfi_unloader_model (.sys_clk(sys_clk), .reset_n(reset_n), .send(send),
    .crc_req(crc_req), .crc_error_in(crc_error_in), .emr_data(emr_data), .emr_valid(emr_valid),
    .emr_ready(emr_ready), .n_sent(n_sent), .last_sent(last_sent));
  task chk_stat(input [47:0] e, input [47:0] s, input [47:0] m);
    begin
      compares = compares + 1;
      if ((s & m) !== (e & m)) begin
        n_fail = n_fail + 1;
        $display("[FAIL] status exp %h got %h", e & m, s & m);
      end
    end
  endtask
  task chk_pulse(input [1:0] e, input [1:0] s);
    begin
      compares = compares + 1;
      if (s !== e) begin
        n_fail = n_fail + 1;
        $display("[FAIL] pulse exp %h got %h", e, s);
      end
    end
  endtask
  // Status expected from the bench's own tally
  function [47:0] now_stat();
    now_stat = {(n_sent == base) ? 32'h0 : last_sent, n_sent - base, 5'h00, crc_exp, |flips, 1'b0};
  endfunction
  // Framed shift; cut pulls reset where the frame would end
  task frame(input [7:0] cmd, input integer n, input cut, input [47:0] m);
    integer i;
    begin
      eq.push_back(now_stat());
      mq.push_back(m);
      for (i = 0; i <= n; i = i + 1) begin
        @(negedge tck);
        @(posedge sys_clk);
        #1 tms = (i == n);
        tdi = cmd[i % 8];
        reset_n = !(cut && i == n);
      end
      @(posedge tck);
      @(posedge sys_clk);
      #1 reset_n = 1'b1;
    end
  endtask
  // Traffic, then one command; waits out any done pulse
  task do_cmd(input [1:0] op, input stall);
    integer i;
    begin
      @(posedge sys_clk);
      #1 send = 1'b1;
      repeat (16) @(posedge sys_clk);
      #1 send = stall;
      repeat (20) @(posedge sys_clk);
      #1 if (op == 2'h1 || op == 2'h2) pq.push_back(op);
      frame({op, a}, 48, 1'b0, stall ? 48'h7 : 48'hFFFF_FFFF_FFF7);
      send = 1'b0;
      if (op == 2'h1) flips[a] = ~flips[a];
      if (op == 2'h2) flips = 64'h0;
      if (op[1]) crc_exp = 1'b0;
      if (op == 2'h3) base = n_sent;
      for (i = 0; i < 400 && (pq.size() > 0 || error_injected || error_scrubbed); i = i + 1)
        @(negedge sys_clk);
      if (i == 400) begin
        n_fail = n_fail + 1;
        results;
      end
      $display("command %0d finished", op);
    end
  endtask
  // Each new done pulse matches the oldest command asking for one
  always @(negedge sys_clk) begin
    if ({error_scrubbed, error_injected} & ~dp)
      chk_pulse(pq.size() ? pq.pop_front() : 2'h0, {error_scrubbed, error_injected} & ~dp);
    dp = {error_scrubbed, error_injected};
  end
  // Status bits taken at shift rises, judged at the end rise
  always @(posedge tck) begin
    full = full | !emr_ready;
    if (!tms) begin
      got[nb] = tdo_out;
      nb = nb + 1;
    end else if (nb > 0) begin
      chk_stat(eq.pop_front(), got, mq.pop_front());
      nb = 0;
    end
  end
  task results;
    begin
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    // A real falling edge, so the async reset acts before the first clock
    #1 reset_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    a = 6'($random(seed));
    for (k = 0; k < 11; k = k + 1) begin
      do_cmd(ops_seq[2*k +: 2], 1'b0);
      if (k == 1) begin
        @(posedge sys_clk);
        #1 crc_req = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1 crc_req = 1'b0;
        crc_exp = 1'b1;
      end
    end
    // Long frame stalls draining; no word may be lost
    do_cmd(2'h0, 1'b1);
    do_cmd(2'h0, 1'b0);
    chk_stat(48'h1, {47'h0, full}, 48'h1);
    // reset mid-frame drops the half command
    frame({2'h1, a}, 5, 1'b1, 48'h7);
    // Reset restores the golden image and clears the sticky flag
    base = 8'h00;
    flips = 64'h0;
    crc_exp = 1'b0;
    $display("reset mid-frame finished");
    do_cmd(2'h0, 1'b0);
    results;
  end
  // Hang guard
  initial begin
    #500000;
    n_fail = n_fail + 1;
    results;
  end
endmodule
bind cfi_port cfi_port_asserts i_cfi_port_asserts (.sys_clk(sys_clk), .reset_n(reset_n),
  .tck(tck), .tms(tms), .tdo_oe_n(tdo_oe_n), .error_injected(error_injected),
  .error_scrubbed(error_scrubbed), .osc_clk_out(osc_clk_out));
